// ---- core/pkts_defs.vh ----
// constants for the power-up kernel test sequencer
`ifndef PKTS_DEFS_VH
`define PKTS_DEFS_VH
// indicator timing in clock cycles
`define PKTS_PULSE_ON 32'd2500000
`define PKTS_PULSE_OFF 32'd2500000
`define PKTS_PAUSE 32'd10000000
`define PKTS_PULSE_COUNT 4'h8
// kernel fault codes
`define PKTS_FAULT_ROM 2'h1
`define PKTS_FAULT_NVM 2'h2
`define PKTS_FAULT_HK 2'h3
// compartment characters, ascii
`define PKTS_CHAR_L 8'h4C
`define PKTS_CHAR_C 8'h43
`define PKTS_CHAR_R 8'h52
// compartment slot encodings
`define PKTS_SLOT_L 2'h0
`define PKTS_SLOT_C 2'h1
`define PKTS_SLOT_R 2'h2
`endif

// ---- core/pkts_fault_flash.v ----
// fault code flasher for the two channel indicators
`timescale 1ns/1ns
`include "pkts_defs.vh"
module pkts_fault_flash #(
    parameter [31:0] ON_CYC = `PKTS_PULSE_ON,
    parameter [31:0] OFF_CYC = `PKTS_PULSE_OFF,
    parameter [31:0] PAUSE_CYC = `PKTS_PAUSE
) (
    input wire mclk_in,
    input wire rst_n_in,
    input wire start_in,
    input wire [1:0] code_in,
    output reg ch1_out,
    output reg ch2_out,
    output wire busy_out
);
    localparam S_IDLE = 2'h0;
    localparam S_ON = 2'h1;
    localparam S_OFF = 2'h2;
    localparam S_PAUSE = 2'h3;
    reg [1:0] st_q;
    reg [31:0] tmr_q;
    reg [3:0] cnt_q;
    reg [1:0] code_q;
    assign busy_out = (st_q != S_IDLE);
    // eight pulses, pause after so repeated displays stay readable
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= S_IDLE;
            tmr_q <= 32'h0;
            cnt_q <= 4'h0;
            code_q <= 2'h0;
            ch1_out <= 1'b0;
            ch2_out <= 1'b0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    ch1_out <= 1'b0;
                    ch2_out <= 1'b0;
                    if (start_in) begin
                        code_q <= code_in;
                        cnt_q <= 4'h1;
                        tmr_q <= ON_CYC - 32'h1;
                        st_q <= S_ON;
                        ch2_out <= 1'b1;
                        ch1_out <= (code_in == 2'h1);
                    end
                end
                S_ON: begin
                    if (tmr_q == 32'h0) begin
                        ch1_out <= 1'b0;
                        ch2_out <= 1'b0;
                        tmr_q <= OFF_CYC - 32'h1;
                        st_q <= S_OFF;
                    end else begin
                        tmr_q <= tmr_q - 32'h1;
                    end
                end
                S_OFF: begin
                    if (tmr_q != 32'h0) begin
                        tmr_q <= tmr_q - 32'h1;
                    end else if (cnt_q == `PKTS_PULSE_COUNT) begin
                        tmr_q <= PAUSE_CYC - 32'h1;
                        st_q <= S_PAUSE;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                        tmr_q <= ON_CYC - 32'h1;
                        ch2_out <= 1'b1;
                        ch1_out <= (cnt_q + 4'h1 == {2'h0, code_q});
                        st_q <= S_ON;
                    end
                end
                S_PAUSE: begin
                    if (tmr_q == 32'h0) begin
                        st_q <= S_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 32'h1;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule // pkts_fault_flash

// ---- core/pkts_sequencer.v ----
// power-up kernel test and self-test sequencer
`timescale 1ns/1ns
`include "pkts_defs.vh"
// Notes on behaviour
// - after reset the kernel checks run in order: program checksum, nvm, housekeeping chip.
// - a kernel failure pulses the second channel indicator exactly eight times.
// - the first channel indicator lights only on the pulse whose count equals the failing test.
// - a program checksum mismatch reports code 1 and then still goes on.
// - the nvm check restores each location so calibration data stays unchanged.
// - an nvm failure reports code 2 and repeats the check forever, no mainframe link.
// - a bad calibration checksum loads defaults and flags a checksum error.
// - a housekeeping signature mismatch reports code 3 and loops that test forever.
// - settings are initialised and the link opened only after the nvm and housekeeping checks pass.
// - failure codes are a compartment character and four hex digits.
// - the compartment character is L, C or R for the installed slot.
// - a front-panel change during self-test counts as a failure.
// - the first failure code and the failure count are kept for the block.
// - any self-test failure leads to extended diagnostics.
// - a new configuration runs a partial recalibration, normal only on success.
module pkts_sequencer #(
    parameter [31:0] ON_CYC = `PKTS_PULSE_ON,
    parameter [31:0] OFF_CYC = `PKTS_PULSE_OFF,
    parameter [31:0] PAUSE_CYC = `PKTS_PAUSE
) (
    // clock and reset
    input wire mclk_in,
    input wire rst_n_in,
    // kernel check engines
    output reg rom_start_out,
    input wire rom_done_in,
    input wire [15:0] rom_sum_in,
    input wire [15:0] rom_stored_in,
    output reg nvm_start_out,
    input wire nvm_done_in,
    input wire nvm_fail_in,
    input wire cal_sum_ok_in,
    output reg hk_start_out,
    input wire hk_done_in,
    input wire [15:0] hk_sig_in,
    input wire [15:0] hk_good_in,
    // mainframe side
    input wire [1:0] slot_in,
    input wire new_config_in,
    input wire selftest_req_in,
    input wire selftest_dis_in,
    output reg init_out,
    output reg link_en_out,
    output reg cal_default_out,
    output reg cal_err_out,
    // self-test engine
    output reg st_run_out,
    input wire st_done_in,
    input wire st_fail_in,
    input wire [15:0] st_code_in,
    input wire [7:0] panel_in,
    output reg [7:0] err_char_out,
    output reg [15:0] err_code_out,
    output reg [7:0] err_count_out,
    // recalibration
    output reg recal_start_out,
    input wire recal_done_in,
    input wire recal_ok_in,
    // status
    output reg ext_diag_out,
    output reg normal_out,
    output reg [1:0] kfault_out,
    // indicators
    output wire first_channel_indicator_out,
    output wire second_channel_indicator_out
);
    // kernel check states
    localparam S_ROM = 4'h0;
    localparam S_ROMW = 4'h1;
    localparam S_NVM = 4'h2;
    localparam S_NVMW = 4'h3;
    localparam S_HK = 4'h4;
    localparam S_HKW = 4'h5;
    // link, self-test and recalibration states
    localparam S_INIT = 4'h6;
    localparam S_WREQ = 4'h7;
    localparam S_ST = 4'h8;
    localparam S_RECAL = 4'h9;
    localparam S_RECW = 4'hA;
    localparam S_NORM = 4'hB;
    localparam S_DIAG = 4'hC;
    // kernel fault display states
    localparam S_FLASH = 4'hD;
    localparam S_FWAIT = 4'hE;

    // internal reset copy, sequence state and flasher handshake
    reg rs1_q;
    reg rst_n;
    reg [3:0] st_q;
    reg [3:0] after_q;
    reg [1:0] code_q;
    reg fl_start_q;
    reg [7:0] panel_prev_q;
    reg fl_seen_q;
    // synchronised pins and the combinational self-test failure
    wire fl_busy;
    wire [2:0] in_s;
    wire [7:0] panel_s;
    wire [1:0] slot_s;
    wire st_bad;

    // reset release through two flops
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    // pins from the mainframe and panel are asynchronous
    pkts_sync2 #(.W(3)) u_sync_ctl (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .d_in({new_config_in, selftest_req_in, selftest_dis_in}),
        .q_out(in_s)
    );
    // slot and panel share one synchroniser so their bits move together
    pkts_sync2 #(.W(10)) u_sync_panel (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .d_in({slot_in, panel_in}),
        .q_out({slot_s, panel_s})
    );

    // flasher owns both indicators; its timing stays a parameter for simulation
    pkts_fault_flash #(
        .ON_CYC(ON_CYC),
        .OFF_CYC(OFF_CYC),
        .PAUSE_CYC(PAUSE_CYC)
    ) u_flash (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .start_in(fl_start_q),
        .code_in(code_q),
        .ch1_out(first_channel_indicator_out),
        .ch2_out(second_channel_indicator_out),
        .busy_out(fl_busy)
    );

    // panel disturbance during the self-test run is a failure
    assign st_bad = st_fail_in || (panel_s != panel_prev_q);

    // main sequence
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_ROM;
            after_q <= S_NVM;
            code_q <= 2'h0;
            fl_start_q <= 1'b0;
            fl_seen_q <= 1'b0;
            panel_prev_q <= 8'h00;
            rom_start_out <= 1'b0;
            nvm_start_out <= 1'b0;
            hk_start_out <= 1'b0;
            init_out <= 1'b0;
            link_en_out <= 1'b0;
            cal_default_out <= 1'b0;
            cal_err_out <= 1'b0;
            st_run_out <= 1'b0;
            err_char_out <= 8'h00;
            err_code_out <= 16'h0000;
            err_count_out <= 8'h00;
            recal_start_out <= 1'b0;
            ext_diag_out <= 1'b0;
            normal_out <= 1'b0;
            kfault_out <= 2'h0;
        end else begin
            // strobes last one cycle, so they are cleared on every edge
            rom_start_out <= 1'b0;
            nvm_start_out <= 1'b0;
            hk_start_out <= 1'b0;
            init_out <= 1'b0;
            recal_start_out <= 1'b0;
            fl_start_q <= 1'b0;
            panel_prev_q <= panel_s;
            case (st_q)
                // kernel check one: program checksum
                S_ROM: begin
                    rom_start_out <= 1'b1;
                    st_q <= S_ROMW;
                end
                S_ROMW: if (rom_done_in) begin
                    if (rom_sum_in != rom_stored_in) begin
                        code_q <= `PKTS_FAULT_ROM;
                        after_q <= S_NVM;
                        st_q <= S_FLASH;
                    end else begin
                        st_q <= S_NVM;
                    end
                end
                // kernel check two: nvm, a failure comes back here
                S_NVM: begin
                    // engine saves and restores each word
                    nvm_start_out <= 1'b1;
                    st_q <= S_NVMW;
                end
                S_NVMW: if (nvm_done_in) begin
                    if (nvm_fail_in) begin
                        code_q <= `PKTS_FAULT_NVM;
                        after_q <= S_NVM;
                        st_q <= S_FLASH;
                    end else begin
                        if (!cal_sum_ok_in) begin
                            cal_default_out <= 1'b1;
                            cal_err_out <= 1'b1;
                        end
                        st_q <= S_HK;
                    end
                end
                // kernel check three: housekeeping signature
                S_HK: begin
                    hk_start_out <= 1'b1;
                    st_q <= S_HKW;
                end
                S_HKW: if (hk_done_in) begin
                    if (hk_sig_in != hk_good_in) begin
                        code_q <= `PKTS_FAULT_HK;
                        after_q <= S_HK;
                        st_q <= S_FLASH;
                    end else begin
                        st_q <= S_INIT;
                    end
                end
                // hand the code to the flasher and wait it out
                S_FLASH: begin
                    kfault_out <= code_q;
                    fl_start_q <= 1'b1;
                    fl_seen_q <= 1'b0;
                    st_q <= S_FWAIT;
                end
                S_FWAIT: begin
                    // wait for the flasher to start then finish
                    if (fl_busy) begin
                        fl_seen_q <= 1'b1;
                    end else if (fl_seen_q) begin
                        st_q <= after_q;
                    end
                end
                // nvm and housekeeping checks passed: settings and link
                S_INIT: begin
                    init_out <= 1'b1;
                    link_en_out <= 1'b1;
                    st_q <= S_WREQ;
                end
                // disable wins over a request seen in the same cycle
                S_WREQ: begin
                    if (in_s[0]) begin
                        st_q <= in_s[2] ? S_RECAL : S_NORM;
                    end else if (in_s[1]) begin
                        st_run_out <= 1'b1;
                        err_count_out <= 8'h00;
                        st_q <= S_ST;
                    end
                end
                // count failing cycles up to 255, keep only the first code
                S_ST: begin
                    if (st_bad && err_count_out != 8'hFF) begin
                        if (err_count_out == 8'h00) begin
                            err_code_out <= st_code_in;
                            case (slot_s)
                                `PKTS_SLOT_L: err_char_out <= `PKTS_CHAR_L;
                                `PKTS_SLOT_C: err_char_out <= `PKTS_CHAR_C;
                                default: err_char_out <= `PKTS_CHAR_R;
                            endcase
                        end
                        err_count_out <= err_count_out + 8'h01;
                    end
                    // a failure on the done cycle still counts
                    if (st_done_in) begin
                        st_run_out <= 1'b0;
                        if (st_bad || err_count_out != 8'h00) begin
                            st_q <= S_DIAG;
                        end else begin
                            st_q <= in_s[2] ? S_RECAL : S_NORM;
                        end
                    end
                end
                // new slot or first install: partial recalibration
                S_RECAL: begin
                    recal_start_out <= 1'b1;
                    st_q <= S_RECW;
                end
                // a failed recalibration ends in diagnostics
                S_RECW: if (recal_done_in) begin
                    st_q <= recal_ok_in ? S_NORM : S_DIAG;
                end
                // end states hold until the next reset
                S_NORM: normal_out <= 1'b1;
                S_DIAG: ext_diag_out <= 1'b1;
                default: st_q <= S_ROM;
            endcase
        end
    end
endmodule // pkts_sequencer

// ---- core/pkts_sync2.v ----
// two flip-flop synchroniser
`timescale 1ns/1ns
module pkts_sync2 #(
    parameter W = 1
) (
    input wire mclk_in,
    input wire rst_n_in,
    input wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    // first stage read only by second
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end else begin
            s1_q <= d_in;
            s2_q <= s1_q;
        end
    end
    assign q_out = s2_q;
endmodule // pkts_sync2

// ---- verification/pkts_checker.sv ----
// assertion checker watching the kernel test sequencer ports
`timescale 1ns/1ns
`include "pkts_defs.vh"
module pkts_checker #(
    parameter [31:0] ON_CYC = 32'd4
) (
    // clock and reset
    input wire mclk_in,
    input wire rst_n_in,
    // kernel engines
    input wire rom_start_out,
    input wire nvm_start_out,
    input wire hk_start_out,
    input wire hk_done_in,
    input wire [15:0] hk_sig_in,
    input wire [15:0] hk_good_in,
    // status and indicators
    input wire link_en_out,
    input wire normal_out,
    input wire ext_diag_out,
    input wire [7:0] err_count_out,
    input wire [1:0] kfault_out,
    input wire first_channel_indicator_out,
    input wire second_channel_indicator_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    reg rom_seen_q;
    reg nvm_seen_q;
    reg ch2_prev_q;
    reg [3:0] pc_q;
    reg [31:0] run_q;
    wire rise = second_channel_indicator_out & ~ch2_prev_q;
    wire [3:0] pc_now = pc_q + {3'h0, rise};
    wire any_start = rom_start_out | nvm_start_out | hk_start_out;
    // order flags; pulse count restarts with every check so loops stay legal
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rom_seen_q <= 1'b0;
            nvm_seen_q <= 1'b0;
            ch2_prev_q <= 1'b0;
            pc_q <= 4'h0;
            run_q <= 32'h0;
        end else begin
            rom_seen_q <= rom_seen_q | rom_start_out;
            nvm_seen_q <= nvm_seen_q | nvm_start_out;
            ch2_prev_q <= second_channel_indicator_out;
            pc_q <= any_start ? 4'h0 : pc_now;
            run_q <= second_channel_indicator_out ? run_q + 32'h1 : 32'h0;
        end
    end
    sequence s_hk_pass;
        hk_done_in && (hk_sig_in == hk_good_in);
    endsequence
    sequence s_pulse_end;
        $fell(second_channel_indicator_out);
    endsequence
    property p_order_nvm;
        nvm_start_out |-> rom_seen_q;
    endproperty
    a_order_nvm: assert property (p_order_nvm) else $error("nvm check before rom");
    property p_order_hk;
        hk_start_out |-> nvm_seen_q;
    endproperty
    a_order_hk: assert property (p_order_hk) else $error("hk check before nvm");
    property p_pulse_cnt;
        rise |-> pc_q < `PKTS_PULSE_COUNT;
    endproperty
    a_pulse_cnt: assert property (p_pulse_cnt) else $error("too many pulses");
    property p_ch1_slot;
        first_channel_indicator_out |->
            second_channel_indicator_out && pc_now == {2'h0, kfault_out};
    endproperty
    a_ch1_slot: assert property (p_ch1_slot) else $error("ch1 on wrong pulse");
    property p_on_width;
        s_pulse_end |-> run_q == ON_CYC;
    endproperty
    a_on_width: assert property (p_on_width) else $error("pulse width");
    property p_nvm_stuck;
        kfault_out == `PKTS_FAULT_NVM |-> !link_en_out;
    endproperty
    a_nvm_stuck: assert property (p_nvm_stuck) else $error("link after nvm fault");
    property p_hk_stuck;
        kfault_out == `PKTS_FAULT_HK |-> !link_en_out && !normal_out;
    endproperty
    a_hk_stuck: assert property (p_hk_stuck) else $error("link after hk fault");
    property p_link_after_hk;
        s_hk_pass |-> ##[1:6] link_en_out;
    endproperty
    a_link_after_hk: assert property (p_link_after_hk) else $error("no link");
    property p_normal_clean;
        normal_out |-> !ext_diag_out && err_count_out == 8'h00;
    endproperty
    a_normal_clean: assert property (p_normal_clean) else $error("normal with fails");
endmodule // pkts_checker

// ---- verification/pkts_host_model.sv ----
// partner model: kernel engines, self-test engine and recalibration answers
`timescale 1ns/1ns
module pkts_host_model (
    // clock and requests
    input wire mclk_in,
    input wire rom_start_in,
    input wire nvm_start_in,
    input wire hk_start_in,
    input wire st_run_in,
    input wire recal_start_in,
    // scenario controls: bad bits rom nvm cal hk recal
    input wire [4:0] bad_in,
    input wire [3:0] lat_in,
    input wire [1:0] nfail_in,
    // answers: done bits rom nvm hk st recal
    output reg [4:0] done_out,
    output wire [15:0] rom_sum_out,
    output wire [15:0] rom_stored_out,
    output wire nvm_fail_out,
    output wire cal_sum_ok_out,
    output wire [15:0] hk_sig_out,
    output wire [15:0] hk_good_out,
    output wire st_fail_out,
    output wire [15:0] st_code_out,
    output wire recal_ok_out
);
    reg [4:0] pend_q = 5'h00;
    reg [3:0] cnt_q = 4'h0;
    reg [3:0] fcnt_q = 4'h0;
    reg st_prev_q = 1'b0;
    wire [4:0] go = {rom_start_in, nvm_start_in, hk_start_in, st_run_in & ~st_prev_q,
        recal_start_in};
    // one engine at a time, answering lat_in+2 cycles after its start strobe rises
    always @(posedge mclk_in) begin
        done_out <= 5'h00;
        st_prev_q <= st_run_in;
        fcnt_q <= st_run_in ? fcnt_q + {3'h0, fcnt_q != 4'hF} : 4'h0;
        if (|go) begin
            pend_q <= go;
            cnt_q <= lat_in;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            done_out <= pend_q;
            pend_q <= 5'h00;
        end
    end
    // result lines show a wrong value outside done, never a held one
    assign rom_stored_out = 16'hC3A5;
    assign rom_sum_out = done_out[4] ? (bad_in[4] ? 16'h0F0F : 16'hC3A5) : 16'h3C5A;
    assign nvm_fail_out = done_out[3] ? bad_in[3] : ~bad_in[3];
    assign cal_sum_ok_out = done_out[3] ? ~bad_in[2] : bad_in[2];
    assign hk_good_out = 16'h5EED;
    assign hk_sig_out = done_out[2] ? (bad_in[1] ? 16'h0BAD : 16'h5EED) : 16'hA112;
    assign recal_ok_out = done_out[0] ? ~bad_in[0] : bad_in[0];
    // first nfail_in cycles of a run fail; codes are block area routine mode
    assign st_fail_out = st_run_in && fcnt_q < {2'h0, nfail_in};
    assign st_code_out = st_fail_out ? 16'h1241 + {12'h0, fcnt_q} : 16'hEDBE;
endmodule // pkts_host_model

// ---- verification/pkts_sequencer_tb_top.sv ----
// self-checking testbench for the power-up kernel test sequencer
`timescale 1ns/1ns
`include "pkts_defs.vh"
module pkts_sequencer_tb_top;
    localparam [31:0] ON_CYC = 32'd4;
    reg mclk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [1:0] slot_in = 2'h1;
    reg new_config_in = 1'b0;
    reg selftest_req_in = 1'b0;
    reg selftest_dis_in = 1'b0;
    reg [7:0] panel_in = 8'h00;
    reg [4:0] bad = 5'h00;
    reg [3:0] lat = 4'h0;
    reg [1:0] nfail = 2'h0;
    wire rom_start_out, nvm_start_out, hk_start_out, st_run_out, recal_start_out;
    wire rom_done_in, nvm_done_in, hk_done_in, st_done_in, recal_done_in;
    wire nvm_fail_in, cal_sum_ok_in, st_fail_in, recal_ok_in;
    wire [15:0] rom_sum_in, rom_stored_in, hk_sig_in, hk_good_in, st_code_in;
    wire init_out, link_en_out, cal_default_out, cal_err_out, ext_diag_out, normal_out;
    wire [7:0] err_char_out, err_count_out;
    wire [15:0] err_code_out;
    wire [1:0] kfault_out;
    wire first_channel_indicator_out, second_channel_indicator_out;
    integer n_errors = 0;
    integer compares = 0;
    integer cyc = 0;
    integer npulse = 0;
    integer ch1_at = 0;
    reg [7:0] ord = 8'h00;
    reg ch2_q = 1'b0;
    reg st_seen = 1'b0;
    reg init_seen = 1'b0;
    integer k;
    pkts_sequencer #(.ON_CYC(ON_CYC), .OFF_CYC(32'd4), .PAUSE_CYC(32'd8)) i_dut (.*);
    pkts_host_model i_host (.mclk_in(mclk_in), .rom_start_in(rom_start_out),
        .nvm_start_in(nvm_start_out), .hk_start_in(hk_start_out), .st_run_in(st_run_out),
        .recal_start_in(recal_start_out), .bad_in(bad), .lat_in(lat), .nfail_in(nfail),
        .done_out({rom_done_in, nvm_done_in, hk_done_in, st_done_in, recal_done_in}),
        .rom_sum_out(rom_sum_in), .rom_stored_out(rom_stored_in), .nvm_fail_out(nvm_fail_in),
        .cal_sum_ok_out(cal_sum_ok_in), .hk_sig_out(hk_sig_in), .hk_good_out(hk_good_in),
        .st_fail_out(st_fail_in), .st_code_out(st_code_in), .recal_ok_out(recal_ok_in));
    // clock
    initial forever #20 mclk_in = ~mclk_in;
    // indicator pulses, check order and hang guard
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        ch2_q <= second_channel_indicator_out;
        if (second_channel_indicator_out && !ch2_q) npulse <= npulse + 1;
        if (first_channel_indicator_out) ch1_at <= npulse + (ch2_q ? 0 : 1);
        if (rom_start_out) ord <= {ord[5:0], `PKTS_FAULT_ROM};
        if (nvm_start_out) ord <= {ord[5:0], `PKTS_FAULT_NVM};
        if (hk_start_out) ord <= {ord[5:0], `PKTS_FAULT_HK};
        st_seen <= st_seen | st_run_out;
        init_seen <= init_seen | init_out;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            final_report;
        end
    end
    task chk(input bit ok, input string msg);
        begin
            compares = compares + 1;
            if (!ok) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: %s", $time, msg);
            end
        end
    endtask
    // configure far side and controls, then reset for two cycles
    task run(input [4:0] b, input [3:0] l, input [1:0] n, input [1:0] s, input [2:0] ctl);
        begin
            @(negedge mclk_in);
            {bad, lat, nfail, slot_in} = {b, l, n, s};
            {selftest_dis_in, selftest_req_in, new_config_in} = ctl;
            rst_n_in = 1'b0;
            {npulse, ch1_at, ord, st_seen, init_seen} = 0;
            repeat (2) @(negedge mclk_in);
            rst_n_in = 1'b1;
        end
    endtask
    // bounded wait for an end state or a repeated kernel check
    task settle;
        integer i;
        begin
            for (i = 0; i < 800 && normal_out !== 1'b1 && ext_diag_out !== 1'b1
                && !(ord[3:2] === ord[1:0] && ord[1:0] != 2'h0); i = i + 1)
                @(negedge mclk_in);
        end
    endtask
    task t_pass;
        begin
            run(5'h00, 4'h0, 2'h0, 2'h1, 3'b010);
            settle;
            chk(ord === 8'h1B, "kernel order");
            chk(init_seen && link_en_out === 1'b1, "init and link");
            chk(st_seen && normal_out === 1'b1 && ext_diag_out === 1'b0, "clean run");
            chk(npulse == 0, "flash without fault");
            chk(cal_default_out === 1'b0 && cal_err_out === 1'b0, "cal flags clean");
            chk(kfault_out === 2'h0 && err_count_out === 8'h00, "no fault kept");
            $display("test pass_path done");
        end
    endtask
    task t_kernel(input [1:0] code, input [4:0] b);
        begin
            run(b, 4'h0, 2'h0, 2'h1, 3'b010);
            settle;
            chk(npulse == 8, "pulse count");
            chk(ch1_at == code, "ch1 pulse index");
            chk(kfault_out === code, "fault code");
            chk(link_en_out === (code == `PKTS_FAULT_ROM), "link state");
            chk(code == `PKTS_FAULT_ROM ? normal_out === 1'b1 : ord[3:0] === {code, code},
                "proceed or repeat");
            $display("test kernel_fault %0d done", code);
        end
    endtask
    task t_selftest(input [1:0] s);
        integer i;
        begin
            run(5'h00, 4'hC, 2'h2, s, 3'b010);
            for (i = 0; i < 300 && st_run_out !== 1'b1; i = i + 1) @(negedge mclk_in);
            repeat (2) @(negedge mclk_in);
            if (s == 2'h2) panel_in = ~panel_in;
            settle;
            chk(err_char_out === (s == 2'h0 ? `PKTS_CHAR_L : s == 2'h1 ? `PKTS_CHAR_C :
                `PKTS_CHAR_R), "compartment char");
            chk(err_code_out === 16'h1241, "first failure code");
            chk(err_count_out === 8'h02 + {7'h0, s == 2'h2}, "failure count");
            chk(ext_diag_out === 1'b1 && normal_out === 1'b0, "diagnostics entry");
            $display("test selftest slot %0d done", s);
        end
    endtask
    task t_recal(input b);
        begin
            run({4'h2, b}, 4'h3, 2'h1, 2'h0, 3'b111);
            settle;
            chk(cal_default_out === 1'b1 && cal_err_out === 1'b1, "default constants");
            chk(!st_seen, "self-test skipped");
            chk(normal_out === ~b && ext_diag_out === b, "recal outcome");
            $display("test recal %0d done", b);
        end
    endtask
    task final_report;
        begin
            $display("compares %0d, mismatches %0d", compares, n_errors);
            if (n_errors == 0 && compares > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // main sequence
    initial begin
        t_pass;
        t_kernel(`PKTS_FAULT_ROM, 5'h10);
        t_kernel(`PKTS_FAULT_NVM, 5'h08);
        t_kernel(`PKTS_FAULT_HK, 5'h02);
        for (k = 0; k < 3; k = k + 1) t_selftest(k[1:0]);
        t_recal(1'b0);
        t_recal(1'b1);
        final_report;
    end
endmodule // pkts_sequencer_tb_top
bind pkts_sequencer pkts_checker #(.ON_CYC(ON_CYC)) i_chk (.*);
